// ===== src/tps_params.svh
/*
 * tps_params.svh: register offsets, field positions, reset values and
 * timing figures of the transport stream protection switch.
 * assumes: included by bare name from the switch module.
 */
`ifndef TPS_PARAMS_SVH
`define TPS_PARAMS_SVH

// register byte offsets, one 32-bit word each
`define TPS_A_CTRL      8'h00
`define TPS_A_CMD       8'h04
`define TPS_A_PERSIST   8'h08
`define TPS_A_HOLD      8'h0c
`define TPS_A_VFLOOR    8'h10
`define TPS_A_AFLOOR    8'h14
`define TPS_A_WIDX      8'h18
`define TPS_A_WCFG      8'h1c
`define TPS_A_STATUS    8'h20
`define TPS_A_TABLES    8'h24
`define TPS_A_PCR       8'h28
`define TPS_A_ES        8'h2c
`define TPS_A_PKTLEN    8'h30
`define TPS_A_WRATE     8'h34

// control word fields
`define TPS_C_MODE      1:0
`define TPS_C_AUTO      2
`define TPS_C_RETURN    3
`define TPS_C_BKCHK     4
`define TPS_C_PROG      7:5
`define TPS_CTRL_RST    8'h05
// command word fields (write-only pulses)
`define TPS_K_MAIN      0
`define TPS_K_BACKUP    1
// watcher config fields
`define TPS_W_EN        31
`define TPS_W_PID       28:16
`define TPS_W_MIN       13:0

// timing: tenth-second base derived from the clock rate
`define TPS_TENTH_MS    100
`define TPS_CLK_MHZ     100
`define TPS_TENTHS_SEC  4'd9
`define TPS_PERSIST_MIN 9'd1
`define TPS_PERSIST_MAX 9'd300
`define TPS_PERSIST_RST 9'd20
`define TPS_HOLD_RST    9'd150
`define TPS_FLOOR_MIN   14'd1
`define TPS_FLOOR_MAX   14'd10000
`define TPS_VFLOOR_RST  14'd100
`define TPS_AFLOOR_RST  14'd20
`define TPS_NWATCH      32

`endif

// ===== src/tps_pkg.sv
/*
 * tps_pkg: types shared by the protection switch and its surroundings.
 * assumes: each input arrives as one parsed-packet record per cycle.
 */
package tps_pkg;

    // stream test selection
    typedef enum logic [1:0] {
        TM_OFF    = 2'b00,
        TM_SIMPLE = 2'b01,
        TM_PROG   = 2'b10,
        TM_PID    = 2'b11
    } tps_mode_t;

    // per-input health, lower code wins when several fail
    typedef enum logic [2:0] {
        ST_GOOD   = 3'b000,
        ST_NO_SIG = 3'b001,
        ST_NO_PKT = 3'b010,
        ST_NO_PAT = 3'b011,
        ST_NO_PMT = 3'b100,
        ST_NO_VID = 3'b101,
        ST_NO_AUD = 3'b110,
        ST_NO_TGT = 3'b111
    } tps_stat_t;

    // selector position
    typedef enum logic {
        SEL_MAIN   = 1'b0,
        SEL_BACKUP = 1'b1
    } tps_sel_t;

    // one parsed transport packet, valid for one cycle
    typedef struct packed {
        logic        valid;
        logic        null_pkt;
        logic        pat;
        logic        pmt;
        logic [2:0]  prog;
        logic        pcr;
        logic        video;
        logic        audio;
        logic [12:0] pid;
        logic [7:0]  len;
    } tps_pkt_t;

endpackage : tps_pkg

// ===== src/tps_switch.sv
/*
 * tps_switch: health checks on a main and a backup transport stream and
 * the selector that picks which one feeds the output.
 * assumes: packet records come from parsers on clk; the two lock pins are
 * asynchronous; software uses the single-cycle strobe register port.
 */
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tps_params.svh"

module tps_switch #(
    parameter int unsigned TENTH_CYC = `TPS_TENTH_MS * 1000 * `TPS_CLK_MHZ
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             main_lock,      // async signal detect
    input  wire logic             backup_lock,    // async signal detect
    input  wire tps_pkg::tps_pkt_t main_pkt,
    input  wire tps_pkg::tps_pkt_t backup_pkt,
    input  wire logic [7:0]       addr,
    input  wire logic [31:0]      wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output logic [31:0]           rdata,
    output logic                  sel_backup,     // output routing
    output logic                  ind_main,
    output logic                  ind_backup,
    output logic                  alarm
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [1:0]  sync1_ff, sig_ff;             // lock synchronisers
    logic [31:0] tenth_cnt_ff;                 // tenth-second divider
    logic [3:0]  tenth_idx_ff;                 // tenths within a second
    logic        tenth_tick, sec_tick;         // one-cycle enables
    logic [7:0]  ctrl_ff;                      // mode, auto, return, ...
    logic [8:0]  persist_ff, hold_ff;          // in tenths of a second
    logic [13:0] vfloor_ff, afloor_ff;         // rate floors
    logic [4:0]  widx_ff;                      // watcher index
    logic [31:0] rdata_ff;
    tps_pkg::tps_pkt_t pkt_in [2];
    logic [15:0] cnt_ff  [2][6];               // running counts
    logic [15:0] rate_ff [2][6];               // latched per-second rates
    logic [5:0]  hit     [2];                  // class hits this cycle
    logic [7:0]  cur_len_ff, pkt_len_ff;       // main packet length
    logic        w_en_ff  [`TPS_NWATCH];
    logic [12:0] w_pid_ff [`TPS_NWATCH];
    logic [13:0] w_min_ff [`TPS_NWATCH];
    logic [15:0] w_cnt_ff  [2][`TPS_NWATCH];
    logic [15:0] w_rate_ff [2][`TPS_NWATCH];
    logic [1:0]  w_fail;                       // any enabled watcher short
    tps_pkg::tps_stat_t nxt_stat [2];
    tps_pkg::tps_stat_t stat_ff  [2];
    logic [8:0]  ptmr_ff [2];                  // persistence timers
    logic [1:0]  failed_ff;                    // faulted inputs
    logic [8:0]  htmr_ff;                      // return hold timer
    tps_pkg::tps_sel_t sel_ff, nxt_sel;
    logic        ind_main_ff, ind_backup_ff, alarm_ff;
    tps_pkg::tps_mode_t mode;
    logic        cmd_main, cmd_backup, backup_ok, hold_done;

    // class slots inside the count arrays
    localparam int C_NN = 0, C_PAT = 1, C_PMT = 2;
    localparam int C_PCR = 3, C_VID = 4, C_AUD = 5;

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : sat_inc

    // clamp a written value into a lower and upper bound
    function automatic logic [13:0] clamp14(input logic [31:0] v);
        if (v == 32'h0) return `TPS_FLOOR_MIN;
        if (v > 32'(`TPS_FLOOR_MAX)) return `TPS_FLOOR_MAX;
        return v[13:0];
    endfunction : clamp14

    assign mode       = tps_pkg::tps_mode_t'(ctrl_ff[`TPS_C_MODE]);
    assign pkt_in[0]  = main_pkt;
    assign pkt_in[1]  = backup_pkt;
    assign cmd_main   = wr && addr == `TPS_A_CMD && wdata[`TPS_K_MAIN];
    // main wins when software sets both bits in one write
    assign cmd_backup = wr && addr == `TPS_A_CMD && wdata[`TPS_K_BACKUP]
                        && !wdata[`TPS_K_MAIN];

    ////////////////////////////////////////////////////////////////////////
    // lock pins: two flops before any logic reads them

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= 2'h0;
            sig_ff   <= 2'h0;
        end else begin
            sync1_ff <= {backup_lock, main_lock};
            sig_ff   <= sync1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // common timebase: tenth ticks and second ticks

    assign tenth_tick = (tenth_cnt_ff == TENTH_CYC - 1);
    assign sec_tick   = tenth_tick && tenth_idx_ff == `TPS_TENTHS_SEC;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tenth_cnt_ff <= 32'h0;
            tenth_idx_ff <= 4'h0;
        end else if (tenth_tick) begin
            tenth_cnt_ff <= 32'h0;
            tenth_idx_ff <= sec_tick ? 4'h0 : tenth_idx_ff + 4'h1;
        end else begin
            tenth_cnt_ff <= tenth_cnt_ff + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff    <= `TPS_CTRL_RST;
            persist_ff <= `TPS_PERSIST_RST;
            hold_ff    <= `TPS_HOLD_RST;
            vfloor_ff  <= `TPS_VFLOOR_RST;
            afloor_ff  <= `TPS_AFLOOR_RST;
            widx_ff    <= 5'h0;
        end else if (wr) begin
            case (addr)
                `TPS_A_CTRL:    ctrl_ff <= wdata[7:0];
                // persistence held between 0.1 s and 30 s
                `TPS_A_PERSIST: persist_ff <=
                    (wdata < 32'(`TPS_PERSIST_MIN)) ? `TPS_PERSIST_MIN :
                    (wdata > 32'(`TPS_PERSIST_MAX)) ? `TPS_PERSIST_MAX :
                    wdata[8:0];
                `TPS_A_HOLD:    hold_ff <= (wdata > 32'h1ff) ? 9'h1ff
                                                      : wdata[8:0];
                `TPS_A_VFLOOR:  vfloor_ff <= clamp14(wdata);
                `TPS_A_AFLOOR:  afloor_ff <= clamp14(wdata);
                `TPS_A_WIDX:    widx_ff <= wdata[4:0];
                default: ;
            endcase
        end
    end

    // watcher config, written through the index register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int w = 0; w < `TPS_NWATCH; w++) begin
                w_en_ff[w]  <= 1'b0;
                w_pid_ff[w] <= 13'h0;
                w_min_ff[w] <= 14'h0;
            end
        end else if (wr && addr == `TPS_A_WCFG) begin
            w_en_ff[widx_ff]  <= wdata[`TPS_W_EN];
            w_pid_ff[widx_ff] <= wdata[`TPS_W_PID];
            w_min_ff[widx_ff] <= wdata[`TPS_W_MIN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-input counting, latched on the second boundary

    for (genvar g = 0; g < 2; g++) begin : g_in
        // a PMT only counts for the chosen program, or any when zero
        assign hit[g] = {6{pkt_in[g].valid && !pkt_in[g].null_pkt}} & {
            pkt_in[g].audio, pkt_in[g].video, pkt_in[g].pcr,
            pkt_in[g].pmt && (ctrl_ff[`TPS_C_PROG] == 3'h0 ||
                ctrl_ff[`TPS_C_PROG] == pkt_in[g].prog),
            pkt_in[g].pat, 1'b1};

        for (genvar c = 0; c < 6; c++) begin : g_cls
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_ff[g][c]  <= 16'h0;
                    rate_ff[g][c] <= 16'h0;
                end else if (sec_tick) begin
                    rate_ff[g][c] <= cnt_ff[g][c];
                    cnt_ff[g][c]  <= 16'h0;
                end else if (hit[g][c]) begin
                    cnt_ff[g][c]  <= sat_inc(cnt_ff[g][c]);
                end
            end
        end

        // each watcher counts its own PID; the one packet that can arrive in the
        // boundary cycle is lost, traded for a single-cycle latch
        for (genvar w = 0; w < `TPS_NWATCH; w++) begin : g_w
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    w_cnt_ff[g][w]  <= 16'h0;
                    w_rate_ff[g][w] <= 16'h0;
                end else if (sec_tick) begin
                    w_rate_ff[g][w] <= w_cnt_ff[g][w];
                    w_cnt_ff[g][w]  <= 16'h0;
                end else if (hit[g][C_NN] &&
                             pkt_in[g].pid == w_pid_ff[w]) begin
                    w_cnt_ff[g][w]  <= sat_inc(w_cnt_ff[g][w]);
                end
            end
        end

        // any enabled watcher short of its minimum
        always_comb begin
            w_fail[g] = 1'b0;
            for (int w = 0; w < `TPS_NWATCH; w++) begin
                if (w_en_ff[w] && w_rate_ff[g][w] < {2'h0, w_min_ff[w]})
                    w_fail[g] = 1'b1;
            end
        end

        // health classification, earliest failing check first
        always_comb begin
            if (mode == tps_pkg::TM_OFF)
                nxt_stat[g] = tps_pkg::ST_GOOD;
            else if (g == 1 && !ctrl_ff[`TPS_C_BKCHK])
                nxt_stat[g] = tps_pkg::ST_GOOD;
            else if (!sig_ff[g])
                nxt_stat[g] = tps_pkg::ST_NO_SIG;
            else if (rate_ff[g][C_NN] == 16'h0)
                nxt_stat[g] = tps_pkg::ST_NO_PKT;
            else if (rate_ff[g][C_PAT] == 16'h0)
                nxt_stat[g] = tps_pkg::ST_NO_PAT;
            else if (mode == tps_pkg::TM_PROG &&
                     rate_ff[g][C_PMT] == 16'h0)
                nxt_stat[g] = tps_pkg::ST_NO_PMT;
            else if (mode == tps_pkg::TM_PROG &&
                     rate_ff[g][C_VID] < {2'h0, vfloor_ff})
                nxt_stat[g] = tps_pkg::ST_NO_VID;
            else if (mode == tps_pkg::TM_PROG &&
                     rate_ff[g][C_AUD] < {2'h0, afloor_ff})
                nxt_stat[g] = tps_pkg::ST_NO_AUD;
            else if (mode == tps_pkg::TM_PID && w_fail[g])
                nxt_stat[g] = tps_pkg::ST_NO_TGT;
            else
                nxt_stat[g] = tps_pkg::ST_GOOD;
        end

        // status register and fault persistence timer
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                stat_ff[g]   <= tps_pkg::ST_GOOD;
                ptmr_ff[g]   <= 9'h0;
                failed_ff[g] <= 1'b0;
            end else begin
                stat_ff[g] <= nxt_stat[g];
                if (stat_ff[g] == tps_pkg::ST_GOOD) begin
                    // any good status breaks the continuous run
                    ptmr_ff[g]   <= 9'h0;
                    failed_ff[g] <= 1'b0;
                end else begin
                    if (tenth_tick && ptmr_ff[g] != 9'h1ff)
                        ptmr_ff[g] <= ptmr_ff[g] + 9'h1;
                    if (ptmr_ff[g] >= persist_ff)
                        failed_ff[g] <= 1'b1;
                end
            end
        end

        chk_persist_wait: assert property (
            @(posedge clk) disable iff (!nrst)
            $rose(failed_ff[g]) |-> $past(ptmr_ff[g]) >= $past(persist_ff)
        ) else $error("fault raised before persistence elapsed");

        chk_off_good: assert property (
            @(posedge clk) disable iff (!nrst)
            mode == tps_pkg::TM_OFF ##1 mode == tps_pkg::TM_OFF
            |-> stat_ff[g] == tps_pkg::ST_GOOD
        ) else $error("status not good with tests off");

        chk_rate_latch: assert property (
            @(posedge clk) disable iff (!nrst)
            sec_tick |=> rate_ff[g][C_VID] == $past(cnt_ff[g][C_VID])
                      && cnt_ff[g][C_VID] == 16'h0
        ) else $error("video rate not latched at second boundary");
    end

    chk_no_signal: assert property (
        @(posedge clk) disable iff (!nrst)
        !sig_ff[0] && mode != tps_pkg::TM_OFF
        |=> stat_ff[0] == tps_pkg::ST_NO_SIG
    ) else $error("lost lock not reported as no signal");

    ////////////////////////////////////////////////////////////////////////
    // main packet length seen in the last second, zero when none

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_len_ff <= 8'h0;
            pkt_len_ff <= 8'h0;
        end else if (sec_tick) begin
            pkt_len_ff <= cur_len_ff;
            cur_len_ff <= 8'h0;
        end else if (pkt_in[0].valid) begin
            cur_len_ff <= pkt_in[0].len;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selector

    // unchecked backup is trusted, so auto switching still works
    assign backup_ok = !failed_ff[1] &&
                       (stat_ff[1] == tps_pkg::ST_GOOD);
    assign hold_done = htmr_ff >= hold_ff;

    // return hold: main must stay good without a break
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            htmr_ff <= 9'h0;
        else if (stat_ff[0] != tps_pkg::ST_GOOD)
            htmr_ff <= 9'h0;
        else if (tenth_tick && htmr_ff != 9'h1ff)
            htmr_ff <= htmr_ff + 9'h1;
    end

    always_comb begin
        nxt_sel = sel_ff;
        case (sel_ff)
            tps_pkg::SEL_MAIN: begin
                if (cmd_backup)
                    nxt_sel = tps_pkg::SEL_BACKUP;
                else if (!cmd_main && ctrl_ff[`TPS_C_AUTO] &&
                         failed_ff[0] && backup_ok)
                    nxt_sel = tps_pkg::SEL_BACKUP;
            end
            tps_pkg::SEL_BACKUP: begin
                if (cmd_main)
                    nxt_sel = tps_pkg::SEL_MAIN;
                else if (!cmd_backup && ctrl_ff[`TPS_C_AUTO] &&
                         ctrl_ff[`TPS_C_RETURN] && hold_done)
                    nxt_sel = tps_pkg::SEL_MAIN;
            end
            default: nxt_sel = tps_pkg::SEL_MAIN;
        endcase
    end

    // position, indicators and alarm all from their own flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_ff        <= tps_pkg::SEL_MAIN;
            ind_main_ff   <= 1'b1;
            ind_backup_ff <= 1'b0;
            alarm_ff      <= 1'b0;
        end else begin
            sel_ff        <= nxt_sel;
            ind_main_ff   <= (nxt_sel == tps_pkg::SEL_MAIN);
            ind_backup_ff <= (nxt_sel == tps_pkg::SEL_BACKUP);
            alarm_ff      <= failed_ff[0];
        end
    end

    chk_auto_switch: assert property (
        @(posedge clk) disable iff (!nrst)
        sel_ff == tps_pkg::SEL_MAIN && ctrl_ff[`TPS_C_AUTO] &&
        failed_ff[0] && backup_ok && !cmd_main
        |=> sel_ff == tps_pkg::SEL_BACKUP && ind_backup
    ) else $error("auto switch to backup missed");

    chk_main_cmd: assert property (
        @(posedge clk) disable iff (!nrst)
        cmd_main |=> sel_ff == tps_pkg::SEL_MAIN && ind_main && !ind_backup
    ) else $error("main command not obeyed");

    chk_backup_cmd: assert property (
        @(posedge clk) disable iff (!nrst)
        cmd_backup |=> sel_backup && ind_backup && !ind_main
    ) else $error("backup command not obeyed");

    chk_stay_backup: assert property (
        @(posedge clk) disable iff (!nrst)
        sel_ff == tps_pkg::SEL_BACKUP && !ctrl_ff[`TPS_C_RETURN] &&
        !cmd_main |=> sel_ff == tps_pkg::SEL_BACKUP
    ) else $error("left backup with return disabled");

    ////////////////////////////////////////////////////////////////////////
    // register reads, data one cycle after the strobe

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 32'h0;
        end else if (rd) begin
            case (addr)
                `TPS_A_CTRL:    rdata_ff <= {24'h0, ctrl_ff};
                `TPS_A_PERSIST: rdata_ff <= {23'h0, persist_ff};
                `TPS_A_HOLD:    rdata_ff <= {23'h0, hold_ff};
                `TPS_A_VFLOOR:  rdata_ff <= {18'h0, vfloor_ff};
                `TPS_A_AFLOOR:  rdata_ff <= {18'h0, afloor_ff};
                `TPS_A_WIDX:    rdata_ff <= {27'h0, widx_ff};
                `TPS_A_WCFG:    rdata_ff <= {w_en_ff[widx_ff], 2'h0,
                    w_pid_ff[widx_ff], 2'h0, w_min_ff[widx_ff]};
                `TPS_A_STATUS:  rdata_ff <= {21'h0, failed_ff,
                    sel_ff, 1'b0, stat_ff[1], 1'b0, stat_ff[0]};
                `TPS_A_TABLES:  rdata_ff <= {rate_ff[0][C_PMT],
                                             rate_ff[0][C_PAT]};
                `TPS_A_PCR:     rdata_ff <= {16'h0, rate_ff[0][C_PCR]};
                `TPS_A_ES:      rdata_ff <= {rate_ff[0][C_AUD],
                                             rate_ff[0][C_VID]};
                `TPS_A_PKTLEN:  rdata_ff <= {24'h0, pkt_len_ff};
                `TPS_A_WRATE:   rdata_ff <= {w_rate_ff[1][widx_ff],
                                             w_rate_ff[0][widx_ff]};
                default:        rdata_ff <= 32'h0;
            endcase
        end else begin
            rdata_ff <= 32'h0;
        end
    end

    assign rdata      = rdata_ff;
    assign sel_backup = sel_ff;
    assign ind_main   = ind_main_ff;
    assign ind_backup = ind_backup_ff;
    assign alarm      = alarm_ff;

endmodule : tps_switch
`default_nettype wire

// ===== dv/tps_src_model.sv
/* tps_src_model: one transport stream source as parsed packet records.
   assumes: runs on the switch clock; a packet every fourth cycle. */
`timescale 1ns/10ps
`default_nettype none
module tps_src_model (
    input  wire logic             clk,
    input  wire logic             sig_on,  // carrier present
    input  wire logic             nul,     // null packets only
    output logic                  lock,
    output var tps_pkg::tps_pkt_t pkt
);
    logic [1:0] ph_ff = 2'h0;  // packet spacing phase
    // pid moves every cycle so a stale record never looks steady
    always_ff @(posedge clk) begin
        ph_ff <= ph_ff + 2'h1;
        pkt.pid <= {11'h0, ph_ff};
        pkt.valid <= sig_on && (ph_ff == 2'h0);
        pkt.null_pkt <= nul;
        {pkt.pat, pkt.pmt, pkt.pcr, pkt.video, pkt.audio} <= {5{~nul}};
        pkt.prog <= 3'h1;
        pkt.len <= 8'hbc;
    end
    assign lock = sig_on;  // no lock without carrier
endmodule : tps_src_model
`default_nettype wire

// ===== dv/tb_transport_stream_protection_switch.sv
/* tb_transport_stream_protection_switch: directed tests of tps_switch.
   assumes: two source models; 100 MHz clock; a tenth is 10 cycles. */
`timescale 1ns/10ps
`default_nettype none
module tb_transport_stream_protection_switch;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic m_on = 1'b1, m_nul = 1'b0, m_lock, b_lock;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, r;
    logic sel_backup, ind_main, ind_backup, alarm;
    tps_pkg::tps_pkt_t m_pkt, b_pkt;
    int n_fail = 0, n_tests = 0, i;
    longint t0;
    always #5 clk = ~clk;
    tps_src_model u_m (.clk(clk), .sig_on(m_on), .nul(m_nul),
                       .lock(m_lock), .pkt(m_pkt));
    tps_src_model u_b (.clk(clk), .sig_on(1'b1), .nul(1'b0),
                       .lock(b_lock), .pkt(b_pkt));
    tps_switch #(.TENTH_CYC(10)) dut (.clk(clk), .nrst(nrst),
        .main_lock(m_lock), .backup_lock(b_lock), .main_pkt(m_pkt),
        .backup_pkt(b_pkt), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sel_backup(sel_backup), .ind_main(ind_main),
        .ind_backup(ind_backup), .alarm(alarm));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one strobe cycle; read data taken in the cycle after it
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 r = rdata;
    endtask : bus
    // bounded poll of the status word
    task automatic poll(input logic [31:0] m, input logic [31:0] e);
        int k;
        bus(1'b0, 8'h20, 32'h0);
        for (k = 0; k < 300 && (r & m) !== e; k++) bus(1'b0, 8'h20, 32'h0);
        chk(r & m, e);
    endtask : poll
    // program and PID modes: floors and watcher minimum against 24-25/s
    task automatic t_modes();
        m_nul <= 1'b0;
        bus(1'b1, 8'h00, 32'h2);
        poll(32'h7, 32'h5);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h14, 32'h7fff);
        bus(1'b0, 8'h14, 32'h0);
        chk(r, 32'd10000);
        poll(32'h7, 32'h6);
        bus(1'b1, 8'h1c, 32'h8000_001e);
        bus(1'b1, 8'h00, 32'h3);
        poll(32'h7, 32'h7);
        $display("test modes done");
    endtask : t_modes
    task automatic give_verdict();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        chk(r, 32'h5);
        chk({sel_backup, ind_main, ind_backup, alarm}, 4'h4);
        bus(1'b1, 8'h04, 32'h2);
        chk({sel_backup, ind_main, ind_backup}, 3'h5);
        bus(1'b0, 8'h20, 32'h0);
        chk(r[8], 1'b1);
        bus(1'b1, 8'h04, 32'h1);
        chk({sel_backup, ind_main, ind_backup}, 3'h2);
        poll(32'h7, 32'h0);
        bus(1'b0, 8'h24, 32'h0);
        chk(r[15:0] >= 24 && r[15:0] <= 25, 1'b1);
        bus(1'b0, 8'h2c, 32'h0);
        chk(r[31:16] >= 24 && r[31:16] <= 25, 1'b1);
        $display("test manual done");
        // carrier loss: persistence of 20 tenths before the switch
        t0 = $time;
        m_on <= 1'b0;
        poll(32'h7, 32'h1);
        for (i = 0; i < 400 && sel_backup !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(($time - t0) / 10 >= 190 && ($time - t0) / 10 <= 235, 1);
        chk({sel_backup, alarm}, 2'h3);
        $display("test failover done");
        // return after 5 good tenths
        bus(1'b1, 8'h0c, 32'h5);
        bus(1'b1, 8'h00, 32'hd);
        m_on <= 1'b1;
        poll(32'h7, 32'h0);
        chk(sel_backup, 1'b1);
        for (i = 0; i < 200 && sel_backup !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk(i >= 40 && i < 80, 1'b1);
        chk(ind_main, 1'b1);
        m_nul <= 1'b1;
        poll(32'h7, 32'h2);
        $display("test recovery done");
        t_modes();
        give_verdict();
    end
    // whole run is about 7 us
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end
endmodule : tb_transport_stream_protection_switch
`default_nettype wire
